// ===== common/pin_bank_pkg.sv
// Purpose: shared constants and carriers for the sixteen-pin control bank
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes:   pin_level reset value is a plain parameter default of zero
`default_nettype none

package pin_bank_pkg;

    localparam int unsigned PIN_COUNT = 16;
    localparam int unsigned ADDR_W    = 12;
    localparam int unsigned DATA_W    = 32;

    localparam logic [ADDR_W-1:0] OFS_FUNC_SEL = 12'h338;
    localparam logic [ADDR_W-1:0] OFS_DIR      = 12'h33C;
    localparam logic [ADDR_W-1:0] OFS_LEVEL    = 12'h340;

    localparam logic [PIN_COUNT-1:0] RST_FUNC_SEL = 16'h0000;
    localparam logic [PIN_COUNT-1:0] RST_DIR      = 16'h0000;
    localparam logic [PIN_COUNT-1:0] RST_LEVEL    = 16'h0000;
    localparam logic [DATA_W-1:0]    RD_UNMAPPED  = 32'h0000_0000;

    // every pin's drive view: enable and level vectors
    typedef struct packed {
        logic [PIN_COUNT-1:0] oe;
        logic [PIN_COUNT-1:0] level;
    } pin_drive_s;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } bus_state_e;

endpackage : pin_bank_pkg

`default_nettype wire

// ===== verilog/gpio_pin_control_bank.sv
// Purpose: sixteen general purpose pins with select, direction, level registers
// Assumes: ref_clk_in 250 MHz, rst_n_in asynchronous active low
// Notes:   ack one cycle after request, then one idle cycle before next ack
`default_nettype none

module gpio_pin_control_bank
    import pin_bank_pkg::*;
(
    // clock and reset
    input  wire logic                 ref_clk_in,
    input  wire logic                 rst_n_in,
    // wishbone slave
    input  wire logic                 wb_cyc_in,
    input  wire logic                 wb_stb_in,
    input  wire logic                 wb_we_in,
    input  wire logic [ADDR_W-1:0]    wb_adr_in,
    input  wire logic [3:0]           wb_sel_in,
    input  wire logic [DATA_W-1:0]    wb_dat_in,
    output logic      [DATA_W-1:0]    wb_dat_out,
    output logic                      wb_ack_out,
    // pins
    input  wire logic [PIN_COUNT-1:0] pin_in,
    output logic      [PIN_COUNT-1:0] pin_out,
    output logic      [PIN_COUNT-1:0] pin_oe_out,
    // alternate function side
    input  wire logic [PIN_COUNT-1:0] alt_out_in,
    input  wire logic [PIN_COUNT-1:0] alt_oe_in,
    output logic      [PIN_COUNT-1:0] alt_mode_out
);

    logic [PIN_COUNT-1:0] func_sel_reg, func_sel_next;
    logic [PIN_COUNT-1:0] dir_reg,      dir_next;
    logic [PIN_COUNT-1:0] level_reg,    level_next;
    logic [PIN_COUNT-1:0] sync1_reg, sync2_reg;
    logic [PIN_COUNT-1:0] alt_out_s1_reg, alt_out_s2_reg;
    logic [PIN_COUNT-1:0] alt_oe_s1_reg,  alt_oe_s2_reg;
    bus_state_e           bus_state_reg, bus_state_next;
    logic                 ack_reg, ack_next;
    logic [DATA_W-1:0]    rd_data_reg, rd_data_next;
    pin_drive_s           drive_reg, drive_next;

    // width of one byte lane of the write enables
    localparam int unsigned LANE_W = PIN_COUNT / 2;

    // merge a written 16-bit field by byte lanes
    function automatic logic [PIN_COUNT-1:0] lane_merge(
        input logic [PIN_COUNT-1:0] old_val,
        input logic [DATA_W-1:0]    wr_val,
        input logic [3:0]           sel
    );
        logic [PIN_COUNT-1:0] res;
        res = old_val;
        if (sel[0]) begin
            res[LANE_W-1:0] = wr_val[LANE_W-1:0];
        end
        if (sel[1]) begin
            res[PIN_COUNT-1:LANE_W] = wr_val[PIN_COUNT-1:LANE_W];
        end
        return res;
    endfunction

    function automatic logic [DATA_W-1:0] zero_ext(input logic [PIN_COUNT-1:0] v);
        return {{(DATA_W-PIN_COUNT){1'b0}}, v};
    endfunction

    // request taken only from idle so ack falls after one cycle
    logic req_take;
    assign req_take = wb_cyc_in && wb_stb_in && (bus_state_reg == BUS_IDLE);

    always_comb begin
        func_sel_next  = func_sel_reg;
        dir_next       = dir_reg;
        level_next     = level_reg;
        bus_state_next = BUS_IDLE;
        rd_data_next   = rd_data_reg;
        ack_next       = 1'b0;
        if (req_take) begin
            bus_state_next = BUS_ACK;
            ack_next       = 1'b1;
            unique case (wb_adr_in)
                OFS_FUNC_SEL: begin
                    rd_data_next = zero_ext(func_sel_reg);
                    if (wb_we_in) begin
                        func_sel_next = lane_merge(func_sel_reg, wb_dat_in, wb_sel_in);
                    end
                end
                OFS_DIR: begin
                    rd_data_next = zero_ext(dir_reg);
                    if (wb_we_in) begin
                        dir_next = lane_merge(dir_reg, wb_dat_in, wb_sel_in);
                    end
                end
                OFS_LEVEL: begin
                    rd_data_next = zero_ext(sync2_reg);
                    if (wb_we_in) begin
                        // stored always; only reaches pins that are gp outputs
                        level_next = lane_merge(level_reg, wb_dat_in, wb_sel_in);
                    end
                end
                default: begin
                    rd_data_next = RD_UNMAPPED;
                end
            endcase
        end
    end

    // pin drive resolution
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (func_sel_reg[i]) begin
                drive_next.oe[i]    = alt_oe_s2_reg[i];
                drive_next.level[i] = alt_out_s2_reg[i];
            end else begin
                drive_next.oe[i]    = dir_reg[i];
                drive_next.level[i] = dir_reg[i] & level_reg[i];
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            func_sel_reg   <= RST_FUNC_SEL;
            dir_reg        <= RST_DIR;
            level_reg      <= RST_LEVEL;
            sync1_reg      <= '0;
            sync2_reg      <= '0;
            alt_out_s1_reg <= '0;
            alt_out_s2_reg <= '0;
            alt_oe_s1_reg  <= '0;
            alt_oe_s2_reg  <= '0;
            bus_state_reg  <= BUS_IDLE;
            ack_reg        <= 1'b0;
            rd_data_reg    <= '0;
            drive_reg      <= '0;
        end else begin
            func_sel_reg   <= func_sel_next;
            dir_reg        <= dir_next;
            level_reg      <= level_next;
            sync1_reg      <= pin_in;
            sync2_reg      <= sync1_reg;
            alt_out_s1_reg <= alt_out_in;
            alt_out_s2_reg <= alt_out_s1_reg;
            alt_oe_s1_reg  <= alt_oe_in;
            alt_oe_s2_reg  <= alt_oe_s1_reg;
            bus_state_reg  <= bus_state_next;
            ack_reg        <= ack_next;
            rd_data_reg    <= rd_data_next;
            drive_reg      <= drive_next;
        end
    end

    assign wb_ack_out   = ack_reg;
    assign wb_dat_out   = rd_data_reg;
    assign pin_out      = drive_reg.level;
    assign pin_oe_out   = drive_reg.oe;
    assign alt_mode_out = func_sel_reg;

    // checks
    sequence s_level_read;
        req_take && !wb_we_in && (wb_adr_in == OFS_LEVEL);
    endsequence

    sequence s_func_read;
        req_take && !wb_we_in && (wb_adr_in == OFS_FUNC_SEL);
    endsequence

    sequence s_dir_read;
        req_take && !wb_we_in && (wb_adr_in == OFS_DIR);
    endsequence

    sequence s_func_write;
        req_take && wb_we_in && (wb_adr_in == OFS_FUNC_SEL);
    endsequence

    sequence s_dir_write;
        req_take && wb_we_in && (wb_adr_in == OFS_DIR);
    endsequence

    sequence s_level_write;
        req_take && wb_we_in && (wb_adr_in == OFS_LEVEL);
    endsequence

    // unmapped offsets still answer so a stray access cannot hang the bus
    sequence s_unmapped;
        req_take && (wb_adr_in != OFS_FUNC_SEL) && (wb_adr_in != OFS_DIR)
            && (wb_adr_in != OFS_LEVEL);
    endsequence

    // one acknowledge, then a gap that keeps a held request from retaking
    sequence s_ack_pulse;
        ##1 wb_ack_out ##1 !wb_ack_out;
    endsequence

    chk_upper_zero: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        wb_ack_out |-> wb_dat_out[DATA_W-1:PIN_COUNT] == '0)
        else $error("upper read bits not zero");

    chk_alt_owns: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (func_sel_reg[0] && $stable(func_sel_reg)) |=> pin_oe_out[0] == $past(alt_oe_s2_reg[0]))
        else $error("alternate pin not driven by alternate enable");

    chk_gp_dir: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (!func_sel_reg[0]) |=> pin_oe_out[0] == $past(dir_reg[0]))
        else $error("gp pin enable does not follow direction");

    chk_gp_drive: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (!func_sel_reg[1] && dir_reg[1]) |=> pin_out[1] == $past(level_reg[1]))
        else $error("gp output level wrong");

    chk_gp_input: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (!func_sel_reg[2] && !dir_reg[2]) |=> !pin_oe_out[2])
        else $error("gp input is driven");

    chk_alt_ignores: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (func_sel_reg[3] && dir_reg[3] && !alt_oe_s2_reg[3]) |=> !pin_oe_out[3])
        else $error("direction leaked into alternate pin");

    chk_alt_level: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        func_sel_reg[5] |=> pin_out[5] == $past(alt_out_s2_reg[5]))
        else $error("alternate pin level not from alternate side");

    chk_oe_vector: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        1'b1 |=> pin_oe_out == (($past(func_sel_reg) & $past(alt_oe_s2_reg))
                                | (~$past(func_sel_reg) & $past(dir_reg))))
        else $error("pin enable vector wrong");

    chk_out_vector: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        1'b1 |=> pin_out == (($past(func_sel_reg) & $past(alt_out_s2_reg))
                             | (~$past(func_sel_reg) & $past(dir_reg) & $past(level_reg))))
        else $error("pin level vector wrong");

    chk_level_read: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        s_level_read |=> wb_ack_out && wb_dat_out[PIN_COUNT-1:0] == $past(sync2_reg))
        else $error("level read not live pin value");

    chk_func_read: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        s_func_read |=> wb_dat_out[PIN_COUNT-1:0] == $past(func_sel_reg))
        else $error("select read back wrong");

    chk_dir_read: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        s_dir_read |=> wb_dat_out[PIN_COUNT-1:0] == $past(dir_reg))
        else $error("direction read back wrong");

    chk_func_lo: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (s_func_write ##0 wb_sel_in[0])
        |=> alt_mode_out[LANE_W-1:0] == $past(wb_dat_in[LANE_W-1:0]))
        else $error("select low lane not written");

    chk_func_keep: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (s_func_write ##0 !wb_sel_in[0])
        |=> alt_mode_out[LANE_W-1:0] == $past(func_sel_reg[LANE_W-1:0]))
        else $error("select low lane changed without enable");

    chk_dir_hi: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (s_dir_write ##0 wb_sel_in[1])
        |=> dir_reg[PIN_COUNT-1:LANE_W] == $past(wb_dat_in[PIN_COUNT-1:LANE_W]))
        else $error("direction high lane not written");

    chk_dir_keep: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (s_dir_write ##0 !wb_sel_in[1])
        |=> dir_reg[PIN_COUNT-1:LANE_W] == $past(dir_reg[PIN_COUNT-1:LANE_W]))
        else $error("direction high lane changed without enable");

    chk_level_store: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (s_level_write ##0 (wb_sel_in[0] && wb_sel_in[1]))
        |=> level_reg == $past(wb_dat_in[PIN_COUNT-1:0]))
        else $error("level write not stored");

    chk_input_kept: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (s_level_write ##0 (!func_sel_reg[4] && !dir_reg[4] && $stable(dir_reg)))
        |=> ##1 !pin_oe_out[4])
        else $error("write drove an input pin");

    chk_unmapped_rd: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (s_unmapped ##0 !wb_we_in) |=> wb_dat_out == RD_UNMAPPED)
        else $error("unmapped read not zero");

    chk_unmapped_wr: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (s_unmapped ##0 wb_we_in)
        |=> $stable(func_sel_reg) && $stable(dir_reg) && $stable(level_reg))
        else $error("unmapped write changed a register");

    // the release edge itself still runs the reset branch, so skip it
    chk_sync_first: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        rst_n_in |=> sync1_reg == $past(pin_in))
        else $error("pin synchroniser first stage wrong");

    chk_sync_depth: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        rst_n_in |-> ##2 sync2_reg == $past(pin_in, 2))
        else $error("pin synchroniser depth wrong");

    chk_ack_follows: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        req_take |-> s_ack_pulse)
        else $error("taken request not answered once");

    chk_ack_cause: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        wb_ack_out |-> $past(req_take))
        else $error("ack without a taken request");

    chk_ack_state: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        wb_ack_out == (bus_state_reg == BUS_ACK))
        else $error("ack flop disagrees with bus state");

    chk_ack_pulse: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        wb_ack_out |=> !wb_ack_out)
        else $error("ack held beyond one cycle");

endmodule : gpio_pin_control_bank

`default_nettype wire

// ===== testbench/board_model.sv
// Purpose: board wiring seen by the sixteen pins
// Assumes: no pull resistors; an undriven pin follows ext_in
// Notes:   ext_in stands for outside drivers on the board
`default_nettype none

module board_model
    import pin_bank_pkg::*;
(
    // pin side of the bank
    input  wire logic [PIN_COUNT-1:0] pin_in,
    input  wire logic [PIN_COUNT-1:0] oe_in,
    // outside drivers and resolved wire
    input  wire logic [PIN_COUNT-1:0] ext_in,
    output logic      [PIN_COUNT-1:0] lvl_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // the bank wins where it drives, the board elsewhere
    assign lvl_out = (oe_in & pin_in) | (~oe_in & ext_in);
endmodule // board_model

`default_nettype wire

// ===== testbench/testbench.sv
// Purpose: self-checking bench for the pin bank
// Assumes: ack comes within twenty cycles
// Notes:   read data checked by a monitor against queued notes
`default_nettype none

module testbench
    import pin_bank_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic              cyc = 1'b0;
    logic              we = 1'b0;
    logic [ADDR_W-1:0] adr = '0;
    logic [31:0]       wdat = '0;
    logic [31:0]       rdat;
    logic              ack;
    logic [15:0]       p_out, p_oe, lvl, amode, m, d, v, oe, ov;
    logic [15:0]       ext = '0;
    logic [15:0]       a_out = '0;
    logic [15:0]       a_oe = '0;
    logic [3:0]        bsel = 4'hF;
    logic [3:0]        lanes = 4'hF;
    logic [31:0]       notes[$];
    int                err_total = 0;
    int                samples_checked = 0;

    always #2 clk = ~clk;

    gpio_pin_control_bank uut (
        .ref_clk_in(clk), .rst_n_in(rst_n), .wb_cyc_in(cyc), .wb_stb_in(cyc),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(bsel), .wb_dat_in(wdat),
        .wb_dat_out(rdat), .wb_ack_out(ack), .pin_in(lvl), .pin_out(p_out),
        .pin_oe_out(p_oe), .alt_out_in(a_out), .alt_oe_in(a_oe),
        .alt_mode_out(amode));

    board_model brd (.pin_in(p_out), .oe_in(p_oe), .ext_in(ext), .lvl_out(lvl));

    task automatic stop_test;
        $display("mismatches %0d of %0d checks", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask

    // one classic cycle; stb follows cyc
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] dt);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= dt;
        bsel <= lanes;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            err_total++;
            stop_test();
        end
        cyc <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        notes.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0) begin
            if (notes.size() == 0) chk("stray read", 32'h0, 32'h1);
            else chk("read data", notes.pop_front(), rdat);
        end
    end

    initial begin
        void'($urandom(32'hE5E4));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFS_FUNC_SEL, 32'h0);
        rd(OFS_DIR, 32'h0);
        bus(1'b1, OFS_FUNC_SEL, 32'hFFFF_0000);
        rd(OFS_FUNC_SEL, 32'h0);
        bus(1'b1, OFS_DIR, 32'hFFFF_FFFF);
        rd(OFS_DIR, 32'h0000_FFFF);
        rd(12'h344, RD_UNMAPPED);
        lanes = 4'h1;
        bus(1'b1, OFS_DIR, 32'h0000_00A5);
        lanes = 4'h2;
        bus(1'b1, OFS_FUNC_SEL, 32'h0000_5A00);
        lanes = 4'hF;
        bus(1'b1, 12'h344, 32'hFFFF_FFFF);
        rd(OFS_DIR, 32'h0000_FFA5);
        rd(OFS_FUNC_SEL, 32'h0000_5A00);
        for (int i = 0; i < 12; i++) begin
            m = (i == 0) ? 16'h0 : (i == 1) ? 16'hFFFF : 16'($urandom);
            d = 16'($urandom);
            v = 16'($urandom);
            ext <= 16'($urandom);
            a_out <= 16'($urandom);
            a_oe <= 16'($urandom);
            bus(1'b1, OFS_FUNC_SEL, {16'h0, m});
            bus(1'b1, OFS_DIR, {16'h0, d});
            bus(1'b1, OFS_LEVEL, {16'h0, v});
            // alternate inputs and pins settle after three edges
            repeat (6) @(posedge clk);
            oe = (m & a_oe) | (~m & d);
            ov = (m & a_out) | (~m & v);
            chk("alt mode", 32'(m), 32'(amode));
            chk("pin enable", 32'(oe), 32'(p_oe));
            chk("pin level", 32'(ov & oe), 32'(p_out & oe));
            rd(OFS_LEVEL, {16'h0, (oe & ov) | (~oe & ext)});
        end
        // mid-run reset: registers return to defaults, pins released
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk("reset enable", 32'h0, 32'(p_oe));
        chk("reset mode", 32'h0, 32'(amode));
        rst_n <= 1'b1;
        rd(OFS_FUNC_SEL, 32'h0);
        rd(OFS_DIR, 32'h0);
        rd(OFS_LEVEL, {16'h0, ext});
        bus(1'b1, OFS_DIR, 32'h0000_FFFF);
        repeat (6) @(posedge clk);
        rd(OFS_LEVEL, {16'h0, RST_LEVEL});
        repeat (2) @(posedge clk);
        stop_test();
    end
endmodule // testbench

`default_nettype wire
